// [hw/vpc_pkg.sv]
// Package with register map, field layout, reset values and timing constants of the chopper.
package vpc_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] VPC_ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] VPC_ADDR_CHOP   = 8'h04;
    localparam logic [7:0] VPC_ADDR_PWM    = 8'h08;
    localparam logic [7:0] VPC_ADDR_LIMIT  = 8'h0C;
    localparam logic [7:0] VPC_ADDR_HOLD   = 8'h10;
    localparam logic [7:0] VPC_ADDR_STATUS = 8'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int VPC_POS_EN       = 0;
    localparam int VPC_POS_OFF_TIME_SETTING     = 0;
    localparam int VPC_POS_BLANK    = 4;
    localparam int VPC_POS_AMPL     = 0;
    localparam int VPC_POS_GRAD     = 8;
    localparam int VPC_POS_FREQ     = 16;
    localparam int VPC_POS_AUTO     = 18;
    localparam int VPC_POS_SYMM     = 19;
    localparam int VPC_POS_SSOPT    = 20;
    localparam int VPC_POS_STANDSTILL_CURRENT    = 0;
    localparam int VPC_POS_IRUN     = 8;
    localparam int VPC_POS_HDELAY   = 16;
    localparam int VPC_POS_PDDELAY  = 24;
    localparam int VPC_POS_SCALE    = 0;
    localparam int VPC_POS_VMODE    = 8;
    localparam int VPC_POS_HELD     = 9;
    localparam int VPC_POS_DRVEN    = 10;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [3:0]  VPC_RST_OFF_TIME_SETTING   = 4'h0;
    localparam logic [1:0]  VPC_RST_BLANK  = 2'h0;
    localparam logic [7:0]  VPC_RST_AMPL   = 8'h80;
    localparam logic [7:0]  VPC_RST_GRAD   = 8'h00;
    localparam logic [1:0]  VPC_RST_FREQ   = 2'h1;
    localparam logic [4:0]  VPC_RST_IRUN   = 5'h1F;
    localparam logic [4:0]  VPC_RST_STANDSTILL_CURRENT  = 5'h08;
    localparam logic [19:0] VPC_RST_LIMIT  = 20'h00000;

    // ****************************************************************
    // Timing: chopper periods in clocks and the standstill delay unit
    // ****************************************************************
    localparam logic [9:0]  VPC_PER_0      = 10'h200;
    localparam logic [9:0]  VPC_PER_1      = 10'h156;
    localparam logic [9:0]  VPC_PER_2      = 10'h100;
    localparam logic [9:0]  VPC_PER_3      = 10'h0CD;
    localparam int unsigned VPC_TICK_DEF   = 262144;
    localparam int          VPC_TICK_W     = 20;

    typedef enum logic [1:0] {
        VPC_RUN  = 2'b00,
        VPC_WAIT = 2'b01,
        VPC_RAMP = 2'b10,
        VPC_HELD = 2'b11
    } vpc_phase_e;

endpackage

// [hw/vpc_core.sv]
// Voltage-mode PWM chopper with standstill handling and a plain register port.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// Functional notes
// R1 - Standstill options apply only when the standstill current setting is zero.
// R2 - Option takes effect after powerdown delay and hold ramp delay have elapsed.
// R3 - Amplitude regulation freezes while target motor current is zero.
// R4 - A 20-bit microstep interval threshold bounds voltage PWM velocity.
// R5 - Enable bit cleared means voltage PWM chopping is never used.
// R6 - A bit selects automatic regulated or forward velocity based amplitude.
// R7 - PWM frequency is the clock divided by a selectable divider.
// R8 - Gain is velocity factor forward, regulation loop gradient in automatic.
// R9 - Offset is base amplitude forward, re-entry amplitude limit in automatic.
// R10 - Option bit forces a symmetric PWM pattern updated once each cycle.
// R11 - Option field: standstill_option, mode 2 low-side short, mode 3 high-side short.
// R12 - Actual amplitude scaling is readable for load and stall detection.
// R13 - Off-time zero disables driver; 1 to 15 enable it, value otherwise unused.
// R14 - Blank-time field selects the current comparator blanking time.
// R15 - Forward amplitude is offset plus gain times 256 times fstep over fclk.
// R16 - Leaving voltage mode keeps the regulation value as restart point.
// R17 - Zero threshold keeps voltage PWM mode at every velocity.
// R18 - Voltage mode runs when enabled and interval not below threshold.
module vpc_core
    import vpc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = VPC_TICK_DEF
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic [19:0] MICROSTEP_INTERVAL,
    input  wire logic        STANDSTILL,
    input  wire logic        COIL_I_LOW,
    input  wire logic        COIL_I_HIGH,
    output logic             PWM_OUT,
    output logic             VOLTAGE_MODE,
    output logic      [1:0]  BRIDGE_MODE,
    output logic             DRIVER_EN,
    output logic      [1:0]  BLANK_SEL,
    output logic      [4:0]  TARGET_CURRENT,
    output logic      [7:0]  PWM_SCALE
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                  en;
        logic [3:0]            off_time_setting;
        logic [1:0]            blank;
        logic [7:0]            ampl;
        logic [7:0]            grad;
        logic [1:0]            freq;
        logic                  autoscale;
        logic                  symm;
        logic [1:0]            ssopt;
        logic [19:0]           limit;
        logic [4:0]            standstill_current;
        logic [4:0]            irun;
        logic [3:0]            hdelay;
        logic [7:0]            pddelay;
        logic [31:0]           rdata;
        logic                  lo_s1;
        logic                  lo_s2;
        logic                  hi_s1;
        logic                  hi_s2;
        logic [VPC_TICK_W-1:0] tick_cnt;
        logic                  tick;
        vpc_phase_e            phase;
        logic [7:0]            phase_cnt;
        logic [4:0]            cur;
        logic [9:0]            pwm_cnt;
        logic [9:0]            duty;
        logic                  pwm_out;
        logic [7:0]            scale;
        logic                  vmode;
        logic [1:0]            bridge;
        logic                  drv_en;
        logic [1:0]            blank_out;
        logic [4:0]            div_cnt;
        logic [20:0]           div_rem;
        logic [15:0]           div_quo;
        logic [19:0]           div_den;
        logic [7:0]            fwd_amp;
    } vpc_state_s;

    localparam logic [VPC_TICK_W-1:0] TICK_LAST = VPC_TICK_W'(TICK_CYCLES - 1);

    vpc_state_s s_q;
    vpc_state_s s_d;

    logic [9:0]  period;
    logic [17:0] duty_full;
    logic [8:0]  amp_sum;
    logic [8:0]  reg_up;
    logic [20:0] rem_sh;
    logic        wrap;
    logic        half;
    logic        freeze;
    logic        vmode_now;
    logic [9:0]  lead;

    always_comb begin
        s_d = s_q;
        period = VPC_PER_0;
        duty_full = 18'h00000;
        amp_sum = 9'h000;
        reg_up = 9'h000;
        rem_sh = 21'h000000;
        lead = 10'h000;

        // ************************************************************
        // Register port
        // ************************************************************
        if (WR) begin
            case (ADDR)
                VPC_ADDR_GLOBAL: begin
                    s_d.en = WDATA[VPC_POS_EN];
                end
                VPC_ADDR_CHOP: begin
                    s_d.off_time_setting  = WDATA[VPC_POS_OFF_TIME_SETTING +: 4];
                    s_d.blank = WDATA[VPC_POS_BLANK +: 2];
                end
                VPC_ADDR_PWM: begin
                    s_d.ampl      = WDATA[VPC_POS_AMPL +: 8];
                    s_d.grad      = WDATA[VPC_POS_GRAD +: 8];
                    s_d.freq      = WDATA[VPC_POS_FREQ +: 2];
                    s_d.autoscale = WDATA[VPC_POS_AUTO];
                    s_d.symm      = WDATA[VPC_POS_SYMM];
                    s_d.ssopt     = WDATA[VPC_POS_SSOPT +: 2];
                end
                VPC_ADDR_LIMIT: begin
                    s_d.limit = WDATA[19:0]; // R4
                end
                VPC_ADDR_HOLD: begin
                    s_d.standstill_current   = WDATA[VPC_POS_STANDSTILL_CURRENT +: 5];
                    s_d.irun    = WDATA[VPC_POS_IRUN +: 5];
                    s_d.hdelay  = WDATA[VPC_POS_HDELAY +: 4];
                    s_d.pddelay = WDATA[VPC_POS_PDDELAY +: 8];
                end
                default: begin
                end
            endcase
        end

        // Read data is valid only in the cycle after the strobe.
        s_d.rdata = 32'h00000000;
        if (RD) begin
            case (ADDR)
                VPC_ADDR_GLOBAL: s_d.rdata[VPC_POS_EN] = s_q.en;
                VPC_ADDR_CHOP: begin
                    s_d.rdata[VPC_POS_OFF_TIME_SETTING +: 4]  = s_q.off_time_setting;
                    s_d.rdata[VPC_POS_BLANK +: 2] = s_q.blank;
                end
                VPC_ADDR_PWM: begin
                    s_d.rdata[VPC_POS_AMPL +: 8]  = s_q.ampl;
                    s_d.rdata[VPC_POS_GRAD +: 8]  = s_q.grad;
                    s_d.rdata[VPC_POS_FREQ +: 2]  = s_q.freq;
                    s_d.rdata[VPC_POS_AUTO]       = s_q.autoscale;
                    s_d.rdata[VPC_POS_SYMM]       = s_q.symm;
                    s_d.rdata[VPC_POS_SSOPT +: 2] = s_q.ssopt;
                end
                VPC_ADDR_LIMIT: s_d.rdata[19:0] = s_q.limit;
                VPC_ADDR_HOLD: begin
                    s_d.rdata[VPC_POS_STANDSTILL_CURRENT +: 5]   = s_q.standstill_current;
                    s_d.rdata[VPC_POS_IRUN +: 5]    = s_q.irun;
                    s_d.rdata[VPC_POS_HDELAY +: 4]  = s_q.hdelay;
                    s_d.rdata[VPC_POS_PDDELAY +: 8] = s_q.pddelay;
                end
                VPC_ADDR_STATUS: begin
                    s_d.rdata[VPC_POS_SCALE +: 8] = s_q.scale; // R12
                    s_d.rdata[VPC_POS_VMODE]      = s_q.vmode;
                    s_d.rdata[VPC_POS_HELD]       = (s_q.phase == VPC_HELD);
                    s_d.rdata[VPC_POS_DRVEN]      = s_q.drv_en;
                end
                default: begin
                end
            endcase
        end

        // Comparator flags come from the analog side and are resynchronised.
        s_d.lo_s1 = COIL_I_LOW;
        s_d.lo_s2 = s_q.lo_s1;
        s_d.hi_s1 = COIL_I_HIGH;
        s_d.hi_s2 = s_q.hi_s1;

        // ************************************************************
        // Standstill sequencing
        // ************************************************************
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= TICK_LAST) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + VPC_TICK_W'(1);
        end

        case (s_q.phase)
            VPC_RUN: begin
                s_d.cur = s_q.irun;
                s_d.phase_cnt = 8'h00;
                if (STANDSTILL) begin
                    s_d.phase = VPC_WAIT;
                end
            end
            VPC_WAIT: begin
                if (!STANDSTILL) begin
                    s_d.phase = VPC_RUN;
                end else if (s_q.phase_cnt >= s_q.pddelay) begin // R2
                    s_d.phase = VPC_RAMP;
                    s_d.phase_cnt = 8'h00;
                end else if (s_q.tick) begin
                    s_d.phase_cnt = s_q.phase_cnt + 8'h01;
                end
            end
            VPC_RAMP: begin
                if (!STANDSTILL) begin
                    s_d.phase = VPC_RUN;
                end else if (s_q.cur <= s_q.standstill_current) begin
                    s_d.cur = s_q.standstill_current;
                    s_d.phase = VPC_HELD; // R2
                end else if (s_q.hdelay == 4'h0) begin
                    s_d.cur = s_q.standstill_current;
                end else if (s_q.tick) begin
                    if (s_q.phase_cnt >= {4'h0, s_q.hdelay} - 8'h01) begin
                        s_d.phase_cnt = 8'h00;
                        s_d.cur = s_q.cur - 5'h01;
                    end else begin
                        s_d.phase_cnt = s_q.phase_cnt + 8'h01;
                    end
                end
            end
            VPC_HELD: begin
                s_d.cur = s_q.standstill_current;
                if (!STANDSTILL) begin
                    s_d.phase = VPC_RUN;
                end
            end
            default: begin
                s_d.phase = VPC_RUN;
            end
        endcase

        // ************************************************************
        // Mode selection and driver controls
        // ************************************************************
        vmode_now = s_q.en && ((s_q.limit == 20'h00000) // R5 R17
                    || (MICROSTEP_INTERVAL >= s_q.limit)); // R18
        s_d.vmode = vmode_now;
        s_d.drv_en = (s_q.off_time_setting != 4'h0); // R13
        s_d.blank_out = s_q.blank; // R14
        s_d.bridge = 2'h0;
        if (s_q.vmode && (s_q.standstill_current == 5'h00) && (s_q.phase == VPC_HELD)) begin // R1
            s_d.bridge = s_q.ssopt; // R11
        end

        // ************************************************************
        // Forward amplitude: gain * 256 / interval, serially divided
        // ************************************************************
        if (s_q.div_cnt == 5'h00) begin
            s_d.div_rem = 21'h000000;
            s_d.div_quo = {s_q.grad, 8'h00}; // R15
            s_d.div_den = MICROSTEP_INTERVAL;
            s_d.div_cnt = 5'h10;
        end else begin
            rem_sh = {s_q.div_rem[19:0], s_q.div_quo[15]};
            s_d.div_quo = {s_q.div_quo[14:0], 1'b0};
            if (rem_sh >= {1'b0, s_q.div_den}) begin
                rem_sh = rem_sh - {1'b0, s_q.div_den};
                s_d.div_quo[0] = 1'b1;
            end
            s_d.div_rem = rem_sh;
            s_d.div_cnt = s_q.div_cnt - 5'h01;
            if (s_q.div_cnt == 5'h01) begin
                // A zero interval means no motion, so only the offset remains.
                if (s_q.div_den == 20'h00000) begin
                    amp_sum = {1'b0, s_q.ampl};
                end else if (s_d.div_quo[15:8] != 8'h00) begin
                    amp_sum = 9'h1FF;
                end else begin
                    amp_sum = {1'b0, s_q.ampl} + {1'b0, s_d.div_quo[7:0]}; // R8 R9
                end
                s_d.fwd_amp = amp_sum[8] ? 8'hFF : amp_sum[7:0];
            end
        end

        // ************************************************************
        // PWM carrier and amplitude
        // ************************************************************
        case (s_q.freq) // R7
            2'h0: period = VPC_PER_0;
            2'h1: period = VPC_PER_1;
            2'h2: period = VPC_PER_2;
            default: period = VPC_PER_3;
        endcase
        wrap = (s_q.pwm_cnt >= period - 10'h001);
        half = (s_q.pwm_cnt == {1'b0, period[9:1]} - 10'h001);
        s_d.pwm_cnt = wrap ? 10'h000 : s_q.pwm_cnt + 10'h001;

        freeze = (s_q.cur == 5'h00); // R3
        if (vmode_now && !s_q.vmode && s_q.autoscale && (s_q.scale > s_q.ampl)) begin
            s_d.scale = s_q.ampl; // R9
        end else if (s_q.vmode && !s_q.autoscale) begin
            s_d.scale = s_q.fwd_amp; // R6
        end else if (s_q.vmode && wrap && !freeze) begin // R16
            if (s_q.lo_s2) begin
                reg_up = {1'b0, s_q.scale}
                         + ((s_q.grad == 8'h00) ? 9'h001 : {1'b0, s_q.grad}); // R8
                s_d.scale = reg_up[8] ? 8'hFF : reg_up[7:0];
            end else if (s_q.hi_s2 && (s_q.scale != 8'h00)) begin
                s_d.scale = s_q.scale - 8'h01;
            end
        end

        // Symmetric mode trades response time for a pattern centred in each cycle.
        if (wrap || (half && !s_q.symm)) begin // R10
            duty_full = 18'(s_q.scale * period);
            s_d.duty = duty_full[17:8];
        end
        lead = (period - s_q.duty) >> 1;
        if (!s_q.vmode || !s_q.drv_en) begin
            s_d.pwm_out = 1'b0;
        end else if (s_q.symm) begin
            s_d.pwm_out = (s_q.pwm_cnt >= lead) && (s_q.pwm_cnt < lead + s_q.duty); // R10
        end else begin
            s_d.pwm_out = (s_q.pwm_cnt < s_q.duty);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.off_time_setting <= VPC_RST_OFF_TIME_SETTING;
            s_q.blank <= VPC_RST_BLANK;
            s_q.ampl <= VPC_RST_AMPL;
            s_q.grad <= VPC_RST_GRAD;
            s_q.freq <= VPC_RST_FREQ;
            s_q.irun <= VPC_RST_IRUN;
            s_q.standstill_current <= VPC_RST_STANDSTILL_CURRENT;
            s_q.limit <= VPC_RST_LIMIT;
            s_q.phase <= VPC_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    assign PWM_OUT = s_q.pwm_out;
    assign VOLTAGE_MODE = s_q.vmode;
    assign BRIDGE_MODE = s_q.bridge;
    assign DRIVER_EN = s_q.drv_en;
    assign BLANK_SEL = s_q.blank_out;
    assign TARGET_CURRENT = s_q.cur;
    assign PWM_SCALE = s_q.scale;

endmodule // vpc_core

// [tb/vpc_core_checker.sv]
// Port assertions for the voltage-mode chopper.
`timescale 1ns/100ps
module vpc_core_checker
    import vpc_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  ADDR,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        STANDSTILL,
    input wire logic        PWM_OUT,
    input wire logic        VOLTAGE_MODE,
    input wire logic [1:0]  BRIDGE_MODE,
    input wire logic        DRIVER_EN,
    input wire logic [1:0]  BLANK_SEL,
    input wire logic [4:0]  TARGET_CURRENT,
    input wire logic [7:0]  PWM_SCALE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data not idle");
    chk_unmapped_read: assert property (RD && ADDR > VPC_ADDR_STATUS |=> RDATA == 32'h0)
        else $error("unmapped read data");
    chk_status_read: assert property (RD && ADDR == VPC_ADDR_STATUS |=>
        RDATA[7:0] == $past(PWM_SCALE) && RDATA[10] == $past(DRIVER_EN))
        else $error("status read wrong");
    chk_vmode_gate: assert property (!VOLTAGE_MODE [*2] |-> !PWM_OUT)
        else $error("pwm outside voltage mode");
    chk_drv_gate: assert property (!DRIVER_EN ##1 !DRIVER_EN |-> !PWM_OUT)
        else $error("pwm with driver off");
    // The field register and the output copy add two cycles after the write.
    chk_blank_write: assert property ($changed(BLANK_SEL) |->
        $past(WR, 2) && $past(ADDR, 2) == VPC_ADDR_CHOP)
        else $error("stray blank change");
    chk_drven_write: assert property ($changed(DRIVER_EN) |->
        $past(WR, 2) && $past(ADDR, 2) == VPC_ADDR_CHOP)
        else $error("stray driver change");
    chk_bridge_zero: assert property (BRIDGE_MODE != 2'h0 |-> $past(TARGET_CURRENT) == 5'h0)
        else $error("bridge with current");
    chk_bridge_delay: assert property ($rose(STANDSTILL) |=> BRIDGE_MODE == 2'h0)
        else $error("bridge too early");
    chk_bridge_release: assert property ($fell(STANDSTILL) |-> ##2 BRIDGE_MODE == 2'h0)
        else $error("bridge kept in motion");

    cover property (BRIDGE_MODE == 2'h2);
    cover property ($rose(VOLTAGE_MODE));
    cover property (RD && ADDR == VPC_ADDR_STATUS);
endmodule // vpc_core_checker

bind vpc_core vpc_core_checker chk_u (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .STANDSTILL(STANDSTILL), .PWM_OUT(PWM_OUT), .VOLTAGE_MODE(VOLTAGE_MODE),
    .BRIDGE_MODE(BRIDGE_MODE), .DRIVER_EN(DRIVER_EN), .BLANK_SEL(BLANK_SEL),
    .TARGET_CURRENT(TARGET_CURRENT), .PWM_SCALE(PWM_SCALE));

// [tb/vpc_core_bench.sv]
// Self-checking bench for the voltage-mode chopper.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module vpc_core_bench
    import vpc_pkg::*;
;
    localparam int TICK = 4;
    logic        clk = 1'b0;
    logic        rst_n, wr, rd, standstill, i_low, i_high, pwm_out, vmode, drv_en;
    logic [7:0]  addr, scale;
    logic [31:0] wdata, rdata;
    logic [19:0] interval;
    logic [1:0]  bridge, blank;
    logic [4:0]  tcur;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #10 clk = ~clk;

    vpc_core #(.TICK_CYCLES(TICK)) dut_u (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MICROSTEP_INTERVAL(interval), .STANDSTILL(standstill),
        .COIL_I_LOW(i_low), .COIL_I_HIGH(i_high), .PWM_OUT(pwm_out), .VOLTAGE_MODE(vmode),
        .BRIDGE_MODE(bridge), .DRIVER_EN(drv_en), .BLANK_SEL(blank),
        .TARGET_CURRENT(tcur), .PWM_SCALE(scale));

    // ****************
    // Bus tasks and helpers
    // ****************
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk) d = rdata;
    endtask

    function automatic logic [31:0] pwm_word(input logic [7:0] ampl, grad,
        input logic [1:0] freq, input logic aut, sym, input logic [1:0] opt);
        return {10'h000, opt, sym, aut, freq, grad, ampl};
    endfunction

    function automatic logic [31:0] hold_word(input logic [4:0] hold, run,
        input logic [3:0] hd, input logic [7:0] pd);
        return {pd, 4'h0, hd, 3'h0, run, 3'h0, hold};
    endfunction

    task automatic vm_case(input logic en, input logic [19:0] lim, itv, input logic exp);
        wr_reg(VPC_ADDR_GLOBAL, {31'h0, en});
        wr_reg(VPC_ADDR_LIMIT, {12'h000, lim});
        interval <= itv;
        repeat (3) @(posedge clk);
        `CHK("vmode", exp, vmode)
    endtask

    task automatic fwd_case(input logic [7:0] ampl, grad, input logic [19:0] itv,
        input logic [7:0] exp);
        wr_reg(VPC_ADDR_PWM, pwm_word(ampl, grad, 2'h1, 1'b0, 1'b0, 2'h0));
        interval <= itv;
        repeat (60) @(posedge clk);
        `CHK("fwd amp", exp, scale)
    endtask

    task automatic wait_lvl(input logic v);
        int n = 0;
        while (pwm_out !== v && n < 2000) begin @(posedge clk); n++; end
    endtask

    task automatic measure(output int per, output int hi);
        int lo = 0;
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        hi = 0;
        while (pwm_out === 1'b1 && hi < 2000) begin @(posedge clk); hi++; end
        while (pwm_out !== 1'b1 && lo < 2000) begin @(posedge clk); lo++; end
        per = hi + lo;
    endtask

    // Regulation moves only at a period wrap, so the wait spans several periods.
    task automatic reg_step(input logic [7:0] dlt);
        logic [7:0] s0;
        int         n = 0;
        s0 = scale;
        while (scale === s0 && n < 1200) begin @(posedge clk); n++; end
        `CHK("reg step", 8'(s0 + dlt), scale)
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        logic [31:0] d;
        `CHK("run current", 5'h1F, tcur)
        rd_reg(VPC_ADDR_PWM, d);
        `CHK("pwm reset", 32'h0001_0080, d & 32'h0003_FFFF)
        rd_reg(VPC_ADDR_HOLD, d);
        `CHK("hold reset", 32'h0000_1F08, d & 32'h0000_1F1F)
        rd_reg(8'h18, d);
        `CHK("unmapped read", 32'h0, d)
        $display("test reset done");
    endtask

    task automatic t_offtime;
        logic [3:0] toffs [4] = '{4'h0, 4'h1, 4'hF, 4'h7};
        for (int i = 0; i < 4; i++) begin
            wr_reg(VPC_ADDR_CHOP, {26'h0, 2'(i), toffs[i]});
            repeat (2) @(posedge clk);
            `CHK("drv en", toffs[i] != 4'h0, drv_en)
            `CHK("blank", 2'(i), blank)
        end
        $display("test off time done");
    endtask

    task automatic t_threshold;
        vm_case(1'b0, 20'h00000, 20'h00005, 1'b0);
        vm_case(1'b1, 20'h00000, 20'h00005, 1'b1);
        vm_case(1'b1, 20'h00064, 20'h00063, 1'b0);
        vm_case(1'b1, 20'h00064, 20'h00064, 1'b1);
        vm_case(1'b1, 20'hFFFFF, 20'hFFFFE, 1'b0);
        vm_case(1'b1, 20'hFFFFF, 20'hFFFFF, 1'b1);
        $display("test threshold done");
    endtask

    task automatic t_forward;
        wr_reg(VPC_ADDR_LIMIT, 32'h0);
        fwd_case(8'h10, 8'h04, 20'h00040, 8'h20);
        fwd_case(8'h30, 8'h05, 20'h00000, 8'h30);
        fwd_case(8'hF0, 8'hFF, 20'h00001, 8'hFF);
        $display("test forward done");
    endtask

    task automatic t_freq;
        int per_x [4] = '{512, 342, 256, 205};
        int hi_x [4] = '{256, 171, 128, 102};
        int per, hi;
        for (int f = 0; f < 4; f++) begin
            wr_reg(VPC_ADDR_PWM, pwm_word(8'h80, 8'h00, 2'(f), 1'b0, f == 3, 2'h0));
            measure(per, hi);
            measure(per, hi);
            `CHK("period", per_x[f], per)
            `CHK("high time", hi_x[f], hi)
        end
        $display("test frequency done");
    endtask

    task automatic t_auto;
        logic [31:0] d;
        logic [7:0]  s0;
        wr_reg(VPC_ADDR_GLOBAL, 32'h0);
        wr_reg(VPC_ADDR_PWM, pwm_word(8'h20, 8'h03, 2'h2, 1'b1, 1'b0, 2'h0));
        i_low <= 1'b1;
        wr_reg(VPC_ADDR_GLOBAL, 32'h1);
        repeat (3) @(posedge clk);
        `CHK("entry clamp", 1'b1, scale <= 8'h20)
        reg_step(8'h03);
        i_low <= 1'b0;
        i_high <= 1'b1;
        repeat (4) @(posedge clk);
        reg_step(8'hFF);
        rd_reg(VPC_ADDR_STATUS, d);
        `CHK("status mode", 1'b1, d[8])
        wr_reg(VPC_ADDR_LIMIT, 32'h64);
        interval <= 20'h00032;
        repeat (3) @(posedge clk);
        `CHK("mode left", 1'b0, vmode)
        s0 = scale;
        repeat (600) @(posedge clk);
        `CHK("retained", s0, scale)
        interval <= 20'h000C8;
        repeat (3) @(posedge clk);
        `CHK("restart", (s0 > 8'h20) ? 8'h20 : s0, scale)
        wr_reg(VPC_ADDR_LIMIT, 32'h0);
        $display("test auto scaling done");
    endtask

    task automatic t_standstill;
        logic [7:0] s0;
        int         n;
        i_low <= 1'b1;
        i_high <= 1'b0;
        wr_reg(VPC_ADDR_HOLD, hold_word(5'h00, 5'h0A, 4'h1, 8'h02));
        for (int opt = 1; opt < 4; opt++) begin
            wr_reg(VPC_ADDR_PWM, pwm_word(8'h20, 8'h03, 2'h2, 1'b1, 1'b0, 2'(opt)));
            standstill <= 1'b1;
            n = 0;
            while (bridge === 2'h0 && n < 400) begin @(posedge clk); n++; end
            `CHK("bridge", 2'(opt), bridge)
            `CHK("ss delay", 1'b1, n >= 12 * TICK)
            `CHK("held cur", 5'h00, tcur)
            s0 = scale;
            repeat (600) @(posedge clk);
            `CHK("frozen", s0, scale)
            standstill <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK("released", 2'h0, bridge)
            `CHK("run current", 5'h0A, tcur)
        end
        wr_reg(VPC_ADDR_HOLD, hold_word(5'h03, 5'h0A, 4'h1, 8'h02));
        standstill <= 1'b1;
        repeat (200) @(posedge clk);
        `CHK("bridge hold", 2'h0, bridge)
        `CHK("hold cur", 5'h03, tcur)
        standstill <= 1'b0;
        $display("test standstill done");
    endtask

    // ****************
    // Sequence, watchdog and verdict
    // ****************
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        interval = 20'h00000; standstill = 1'b0; i_low = 1'b0; i_high = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset;
        t_offtime;
        t_threshold;
        t_forward;
        t_freq;
        t_auto;
        t_standstill;
        close_out;
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        close_out;
    end
endmodule // vpc_core_bench
